// ### bench/core_exec_assertions.sv
/* Checker of core_exec port timing, flags and mode pulses.
   Assumes it is bound to core_exec and sees only its ports. */
`timescale 1ns/10ps
module core_exec_checker
   import core_exec_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic start,
   input wire op_e op,
   input wire logic watchdog_selected,
   input wire logic data_we,
   input wire logic zero_flag,
   input wire logic carry_flag,
   input wire logic busy,
   input wire logic done,
   input wire logic push_return,
   input wire logic pop_return,
   input wire logic stop_mode,
   input wire logic wait_mode
);
   op_e lop;
   logic lwd;
   logic [3:0] bcnt;
   logic [3:0] ncyc;
   // Instruction latched at start
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         lop <= no_operation;
         lwd <= 1'h0;
      end else if (start && !busy) begin
         lop <= op;
         lwd <= watchdog_selected;
      end
   end
   // Busy cycle counter
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn)
         bcnt <= 4'h0;
      else if (start && !busy)
         bcnt <= 4'h1;
      else if (busy)
         bcnt <= bcnt + 4'h1;
   end
   assign ncyc = (lop inside {branch_if_bit_clear, branch_if_bit_set}) ? CYC_BR_BIT :
      (lop inside {[branch_if_carry:branch_if_nonzero], [no_operation:wait_op]}) ? CYC_CTRL : CYC_ALU;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   sequence take_s;
      start && !busy;
   endsequence
   busy_span_a: assert property ($fell(busy) |-> $past(bcnt) == ncyc)
      else $error("busy span wrong");
   start_take_a: assert property (take_s |=> busy[*2])
      else $error("start not taken");
   done_follow_a: assert property ($fell(busy) |-> done)
      else $error("done missing");
   write_last_a: assert property (data_we |-> busy && bcnt == ncyc)
      else $error("write outside final cycle");
   flags_keep_a: assert property (take_s ##0 (op inside {[branch_if_carry:branch_if_nonzero],
      [bit_set_op:call_op]} && op != return_from_interrupt) |=> $stable({zero_flag, carry_flag})[*5])
      else $error("flags changed");
   carry_keep_a: assert property (take_s ##0 (op inside {increment_op, decrement_op})
      |=> $stable(carry_flag)[*5]) else $error("carry changed");
   zero_keep_a: assert property (take_s ##0 (op inside {branch_if_bit_clear, branch_if_bit_set})
      |=> $stable(zero_flag)[*6]) else $error("zero changed");
   push_call_a: assert property (push_return |-> busy && lop == call_op && bcnt == ncyc)
      else $error("push outside call");
   pop_ret_a: assert property (pop_return |-> busy && lop inside {subroutine_return, return_from_interrupt})
      else $error("pop outside return");
   stop_pick_a: assert property ($fell(busy) && lop == stop_op |-> stop_mode == !lwd && wait_mode == lwd)
      else $error("stop not replaced");
   mode_pulse_a: assert property (stop_mode || wait_mode |-> $fell(busy) && lop inside {stop_op, wait_op})
      else $error("stray mode pulse");
endmodule

bind core_exec core_exec_checker chk_u (.*);

// ### bench/core_exec_tb.sv
/* Self-checking bench for core_exec: random and corner instructions against a model.
   Assumes the bench acts as decoder and as combinational data space. */
`timescale 1ns/10ps
module core_exec_tb
   import core_exec_pkg::*;
;
   logic clk_sys, resetn, start, watchdog_selected, dbl;
   op_e op;
   mode_e mode;
   logic [7:0] opcode, byte2, byte3, saved_flags, data_rdata, ptr_x, ptr_y, data_addr, data_wdata, acc, ea;
   logic [2:0] bit_index;
   logic [11:0] pc_in, return_addr, pc;
   logic [1:0] instr_len;
   logic data_we, zero_flag, carry_flag, busy, done, push_return, pop_return, stop_mode, wait_mode, ez, ec;
   logic [7:0] mem [256];
   logic [7:0] emem [256];
   int n_fail, checks;

   core_exec dut_u (.*);

   assign data_rdata = mem[data_addr];
   assign ptr_x = mem[PTR_X_ADDR];
   assign ptr_y = mem[PTR_Y_ADDR];
   always @(posedge clk_sys) begin
      if (data_we)
         mem[data_addr] <= data_wdata;
   end

   initial begin
      clk_sys = 1'h0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   function automatic int ncyc(op_e o);
      if (o inside {branch_if_bit_clear, branch_if_bit_set})
         return 5;
      return (o inside {[branch_if_carry:branch_if_nonzero], [no_operation:wait_op]}) ? 2 : 4;
   endfunction

   function automatic int nlen(op_e o, mode_e m);
      case (o)
         add_op, and_op, compare_op, subtract_op: return (m == mode_indirect) ? 1 : 2;
         increment_op, decrement_op: return (m == mode_direct) ? 2 : 1;
         clear_op: return (m == mode_direct) ? 3 : 2;
         branch_if_bit_clear, branch_if_bit_set: return 3;
         shift_left_accumulator, bit_set_op, bit_clear_op, long_jump, call_op: return 2;
         default: return 1;
      endcase
   endfunction

   task automatic chk(string nm, logic [11:0] seen, logic [11:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic complete_run;
      if (n_fail == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic rnd;
      op = op_e'($urandom_range(24));
      mode = mode_e'($urandom_range(3));
      if (op == clear_op || op > increment_op)
         mode = mode_direct;
      else if (op < clear_op && mode == mode_short_direct)
         mode = mode_immediate;
      else if (op > clear_op && mode == mode_immediate)
         mode = mode_direct;
      opcode = {1'h0, 7'($urandom)};
      byte2 = 8'($urandom);
      {byte3, bit_index, watchdog_selected, saved_flags, pc_in, return_addr} = 44'({$urandom, $urandom});
      dbl = ($urandom_range(7) == 0);
   endtask

   task automatic do_reset;
      resetn = 1'h0;
      repeat (2) @(posedge clk_sys);
      #1 resetn = 1'h1;
      {ea, ez, ec} = 10'h000;
      chk("reset", {acc, zero_flag, carry_flag, busy, done}, 12'h000);
      chk("reset pc", pc, PC_RESET);
   endtask

   task automatic run;
      logic [7:0] a, v, r;
      logic [11:0] t;
      logic c, af;
      int n;
      af = (op inside {clear_op, increment_op, decrement_op}) && mode == mode_short_direct && opcode[7];
      a = (mode == mode_indirect) ? emem[opcode[4] ? PTR_Y_ADDR : PTR_X_ADDR] :
         (mode == mode_short_direct) ? {6'h20, opcode[1:0]} : byte2;
      v = (mode == mode_immediate) ? byte2 : emem[a];
      t = pc_in + 12'(nlen(op, mode));
      {c, r} = {ec, ea};
      // Accumulator forms of clear, increment and decrement
      if (af) begin
         ea = (op == clear_op) ? 8'h00 : (op == increment_op) ? ea + 8'h01 : ea - 8'h01;
         ez = (ea == 8'h00);
         ec = (op == clear_op) ? 1'h0 : ec;
      end else case (op)
         add_op: {c, r} = ea + v;
         subtract_op, compare_op: {c, r} = ea - v;
         and_op: r = ea & v;
         complement_accumulator: {c, r} = {1'h1, ~ea};
         rotate_left_through_carry: {c, r} = {ea, ec};
         shift_left_accumulator: {c, r} = {ea, 1'h0};
         increment_op, decrement_op: begin
            emem[a] = (op == increment_op) ? v + 8'h01 : v - 8'h01;
            ez = (emem[a] == 8'h00);
         end
         clear_op: emem[a] = 8'h00;
         bit_set_op, bit_clear_op: emem[a][bit_index] = (op == bit_set_op);
         branch_if_carry, branch_if_no_carry, branch_if_zero, branch_if_nonzero: begin
            if (((op < branch_if_zero) ? ec : ez) ^ op[0])
               t = opcode[4] ? pc_in - opcode[3:0] : pc_in + opcode[3:0] + 12'h001;
         end
         branch_if_bit_clear, branch_if_bit_set: begin
            ec = v[bit_index];
            if (ec == (op == branch_if_bit_set))
               t = pc_in + 12'h002 + {{4{byte3[7]}}, byte3};
         end
         long_jump, call_op: t = {opcode[3:0], byte2};
         subroutine_return: t = return_addr;
         return_from_interrupt: {t, ec, ez} = {return_addr, saved_flags[1:0]};
         default: ;
      endcase
      if (op < clear_op || op inside {[complement_accumulator:shift_left_accumulator]}) begin
         {ez, ec} = {r == 8'h00, c};
         if (op != compare_op)
            ea = r;
      end
      start = 1'h1;
      n = 0;
      @(posedge clk_sys);
      #1 start = dbl;
      while (busy === 1'h1 && n < 9) begin
         n++;
         @(posedge clk_sys);
         #1;
         if (n == 1)
            start = 1'h0;
      end
      chk("cycles", 12'(n), 12'(ncyc(op)));
      chk("length", instr_len, 12'(nlen(op, mode)));
      chk("acc", acc, ea);
      chk("flags", {zero_flag, carry_flag}, {ez, ec});
      chk("data", mem[a], emem[a]);
      chk("pc", pc, t);
      chk("modes", {done, stop_mode, wait_mode},
         {1'h1, op == stop_op && !watchdog_selected, op == wait_op || (op == stop_op && watchdog_selected)});
   endtask

   initial begin
      void'($urandom(9));
      n_fail = 0;
      checks = 0;
      start = 1'h0;
      rnd();
      for (int i = 0; i < 256; i++) begin
         mem[i] = 8'($urandom);
         emem[i] = mem[i];
      end
      do_reset();
      for (int i = 0; i < 400; i++) begin
         rnd();
         // Displacement and bit index extremes with a refused restart
         if (i < 8) begin
            op = i[0] ? branch_if_bit_set : branch_if_bit_clear;
            mode = mode_direct;
            byte3 = i[1] ? 8'h80 : 8'h7F;
            bit_index = {3{i[2]}};
            dbl = 1'h1;
         end
         // Clear, increment and decrement aimed at the accumulator
         if (i >= 8 && i < 14) begin
            op = op_e'(clear_op + i % 3);
            mode = mode_short_direct;
            opcode[7] = 1'h1;
         end
         // Reset while an instruction is in flight
         if (i == 200) begin
            start = 1'h1;
            @(posedge clk_sys);
            #1 start = 1'h0;
            do_reset();
         end
         run();
      end
      complete_run();
   end

   // Limit far above 400 instructions of at most 6 cycles each
   initial begin
      #100000;
      n_fail++;
      complete_run();
   end
endmodule

// ### verilog/alu_unit.sv
/*
 Combinational arithmetic and logic unit of the core.
 Assumes the caller selects operands and commits results.
*/
`timescale 1ns/10ps
module alu_unit
   import core_exec_pkg::*;
#(
   parameter int WIDTH = DATA_W
) (
   input wire op_e op,
   input wire logic [WIDTH-1:0] acc,
   input wire logic [WIDTH-1:0] operand,
   input wire logic carry_in,
   output logic [WIDTH-1:0] result,
   output logic carry_out
);
   logic [WIDTH:0] wide;

   always_comb begin
      wide = '0;
      result = acc;
      carry_out = carry_in;
      unique case (op)
         add_op: begin
            wide = {1'b0, acc} + {1'b0, operand};
            result = wide[WIDTH-1:0];
            carry_out = wide[WIDTH];
         end
         and_op: begin
            result = acc & operand;
            carry_out = carry_in;
         end
         compare_op, subtract_op: begin
            wide = {1'b0, acc} - {1'b0, operand};
            result = (op == subtract_op) ? wide[WIDTH-1:0] : acc;
            carry_out = wide[WIDTH];
         end
         complement_accumulator: begin
            result = ~acc;
            carry_out = 1'b1;
         end
         rotate_left_through_carry: begin
            result = {acc[WIDTH-2:0], carry_in};
            carry_out = acc[WIDTH-1];
         end
         shift_left_accumulator: begin
            result = {acc[WIDTH-2:0], 1'b0};
            carry_out = acc[WIDTH-1];
         end
         increment_op: result = operand + 1'b1;
         decrement_op: result = operand - 1'b1;
         clear_op: begin
            result = '0;
            carry_out = 1'b0;
         end
         default: begin
            result = acc;
            carry_out = carry_in;
         end
      endcase
   end
   // Zero flag taken by caller from result, for compare from acc == operand; compare passes acc as result, carry from wide
endmodule

// ### verilog/core_exec.sv
/*
 Execution unit of an 8-bit core: takes a decoded instruction with its
 operand bytes, reads the data space, runs it for its cycle count and
 commits accumulator, flags, data-space writes and program counter.
 Assumes an external fetch/decode stage presents op, mode, opcode and
 operand bytes with a one-cycle start pulse, and a data space that answers
 reads combinationally.
*/
`timescale 1ns/10ps
// Behaviour
// (RQ1) Add, AND, compare, subtract use accumulator and data byte or immediate.
// (RQ2) Clear, decrement, increment reach any of 256 data-space addresses.
// (RQ3) Complement, rotate, shift work on the accumulator only.
// (RQ4) Flag branches taken on carry set/clear, zero set/clear.
// (RQ5) Bit set/clear change one bit of any data byte, others kept.
// (RQ6) Jump and call load a full 12-bit target.
// (RQ7) Flag branches reach from 15 back to 16 forward.
// (RQ8) Bit-test branches use signed byte, reach 126 back to 129 forward.
// (RQ9) Bit-test branch copies tested bit into carry, zero kept.
// (RQ10) With watchdog selected, stop becomes wait.
// (RQ11) ALU and accumulator operations take 4 cycles and update both flags; AND leaves carry unchanged.
// (RQ12) Increment/decrement update zero only; lengths 1 or 2 bytes.
// (RQ13) Clear register is 3 bytes, no flags; clear accumulator 2 bytes, both flags.
// (RQ14) Flag branches: one byte, 2 cycles, flags kept.
// (RQ15) Bit-test branches: three bytes, 5 cycles, on bit 0 or 1.
// (RQ16) Bit set/clear: two bytes, 3-bit index, 4 cycles, flags kept.
// (RQ17) Control ops one byte, 2 cycles; only interrupt return changes flags.
// (RQ18) Jump and call: two bytes, 4 cycles, flags kept.
// (RQ19) Indirect operand address from pointer chosen by opcode bit 4.
// (RQ20) Relative opcode holds direction bit and four-bit span.
// (RQ21) Results commit at end of final cycle.
module core_exec
   import core_exec_pkg::*;
(
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic start,
   input wire op_e op,
   input wire mode_e mode,
   input wire logic [7:0] opcode,
   input wire logic [7:0] byte2,
   input wire logic [7:0] byte3,
   input wire logic [2:0] bit_index,
   input wire logic [11:0] pc_in,
   input wire logic watchdog_selected,
   input wire logic [7:0] saved_flags,
   input wire logic [11:0] return_addr,
   input wire logic [7:0] data_rdata,
   input wire logic [7:0] ptr_x,
   input wire logic [7:0] ptr_y,
   output logic [7:0] data_addr,
   output logic data_we,
   output logic [7:0] data_wdata,
   output logic [7:0] acc,
   output logic zero_flag,
   output logic carry_flag,
   output logic [11:0] pc,
   output logic busy,
   output logic done,
   output logic push_return,
   output logic pop_return,
   output logic stop_mode,
   output logic wait_mode,
   output logic [1:0] instr_len
);
   state_e state;
   op_e cur_op;
   mode_e cur_mode;
   logic [7:0] cur_opcode;
   logic [7:0] cur_b2;
   logic [7:0] cur_b3;
   logic [2:0] cur_bit;
   logic [11:0] cur_pc;
   logic [3:0] cyc_left;
   logic [7:0] operand;
   logic [7:0] alu_res;
   logic alu_carry;
   logic [7:0] next_addr;
   logic [3:0] next_cycles;
   logic [1:0] next_len;
   logic tested_bit;
   logic take;
   logic [11:0] next_pc;
   logic last;

   // One-hot mask for a bit index
   function automatic logic [7:0] bit_mask(input logic [2:0] idx);
      bit_mask = 8'h01 << idx;
   endfunction

   // Classes that work on the accumulator through the ALU
   function automatic logic is_acc_op(input op_e o);
      is_acc_op = (o == add_op) || (o == and_op) || (o == compare_op) || (o == subtract_op) ||
         (o == complement_accumulator) || (o == rotate_left_through_carry) ||
         (o == shift_left_accumulator);
   endfunction

   // Clear, increment or decrement aimed at the accumulator
   function automatic logic is_acc_form(input op_e o, input mode_e m, input logic [7:0] oc);
      is_acc_form = ((o == clear_op) || (o == increment_op) || (o == decrement_op)) &&
         (m == mode_short_direct) && oc[7];
   endfunction

   // Bit-test branch classes
   function automatic logic is_bit_test(input op_e o);
      is_bit_test = (o == branch_if_bit_clear) || (o == branch_if_bit_set);
   endfunction

   // Cycle count per class
   always_comb begin
      unique case (op)
         branch_if_carry, branch_if_no_carry, branch_if_zero, branch_if_nonzero: next_cycles = CYC_BR_REL; // RQ14
         branch_if_bit_clear, branch_if_bit_set: next_cycles = CYC_BR_BIT; // RQ15
         bit_set_op, bit_clear_op: next_cycles = CYC_BIT_OP; // RQ16
         no_operation, subroutine_return, return_from_interrupt, stop_op, wait_op: next_cycles = CYC_CTRL; // RQ17
         long_jump, call_op: next_cycles = CYC_JUMP; // RQ18
         default: next_cycles = CYC_ALU; // RQ11
      endcase
   end

   // Instruction length per class and mode
   always_comb begin
      unique case (op)
         branch_if_carry, branch_if_no_carry, branch_if_zero, branch_if_nonzero,
         no_operation, subroutine_return, return_from_interrupt, stop_op, wait_op,
         complement_accumulator, rotate_left_through_carry: next_len = LEN_1;
         branch_if_bit_clear, branch_if_bit_set: next_len = LEN_3; // RQ15
         bit_set_op, bit_clear_op, long_jump, call_op, shift_left_accumulator: next_len = LEN_2; // RQ16 RQ18
         clear_op: next_len = (mode == mode_direct) ? LEN_3 : LEN_2; // RQ13
         increment_op, decrement_op: next_len = (mode == mode_direct) ? LEN_2 : LEN_1; // RQ12
         default: next_len = (mode == mode_indirect) ? LEN_1 : LEN_2;
      endcase
   end

   // Data-space address of the current operand
   always_comb begin
      unique case (cur_mode)
         mode_indirect: next_addr = cur_opcode[PTR_SEL_BIT] ? ptr_y : ptr_x; // RQ19
         mode_short_direct: next_addr = {6'h20, cur_opcode[1:0]};
         default: next_addr = cur_b2; // RQ2
      endcase
   end
   assign data_addr = next_addr;

   always_comb begin
      operand = (cur_mode == mode_immediate) ? cur_b2 : data_rdata; // RQ1
      if (cur_op == increment_op || cur_op == decrement_op || cur_op == clear_op) begin
         if (cur_mode == mode_short_direct && cur_opcode[7]) begin
            operand = acc;
         end
      end
   end

   alu_unit #(
      .WIDTH(DATA_W)
   ) u_alu (
      .op(cur_op),
      .acc(acc),
      .operand(operand),
      .carry_in(carry_flag),
      .result(alu_res),
      .carry_out(alu_carry)
   );

   assign tested_bit = data_rdata[cur_bit];
   assign last = (state == st_exec) && (cyc_left == 4'h1);

   // Branch condition
   always_comb begin
      unique case (cur_op)
         branch_if_carry: take = carry_flag; // RQ4
         branch_if_no_carry: take = !carry_flag; // RQ4
         branch_if_zero: take = zero_flag; // RQ4
         branch_if_nonzero: take = !zero_flag; // RQ4
         branch_if_bit_clear: take = !tested_bit; // RQ15
         branch_if_bit_set: take = tested_bit; // RQ15
         default: take = 1'b0;
      endcase
   end

   // Target address
   always_comb begin
      next_pc = cur_pc + 12'(instr_len);
      if (cur_op == long_jump || cur_op == call_op) begin
         next_pc = {cur_opcode[3:0], cur_b2}; // RQ6
      end else if (cur_op == subroutine_return || cur_op == return_from_interrupt) begin
         next_pc = return_addr;
      end else if (take && is_bit_test(cur_op)) begin
         next_pc = cur_pc + BIT_BR_BASE + {{4{cur_b3[7]}}, cur_b3}; // RQ8
      end else if (take) begin
         if (cur_opcode[DIR_BIT]) begin // RQ20
            next_pc = cur_pc - {8'h00, cur_opcode[3:0]}; // RQ7
         end else begin
            next_pc = cur_pc + {8'h00, cur_opcode[3:0]} + 12'h001; // RQ7
         end
      end
   end

   // Data-space write for bit ops, clear, increment, decrement
   always_comb begin
      data_we = 1'b0;
      data_wdata = data_rdata;
      if (last) begin
         unique case (cur_op)
            bit_set_op: begin
               data_we = 1'b1;
               data_wdata = data_rdata | bit_mask(cur_bit); // RQ5
            end
            bit_clear_op: begin
               data_we = 1'b1;
               data_wdata = data_rdata & ~bit_mask(cur_bit); // RQ5
            end
            clear_op, increment_op, decrement_op: begin
               data_we = !is_acc_form(cur_op, cur_mode, cur_opcode);
               data_wdata = alu_res; // RQ2
            end
            default: data_we = 1'b0;
         endcase
      end
   end

   // Sequencing
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         state <= st_idle;
         cyc_left <= 4'h0;
      end else begin
         unique case (state)
            st_idle, st_done: begin
               if (start) begin
                  state <= st_exec;
                  cyc_left <= next_cycles;
               end else begin
                  state <= st_idle;
               end
            end
            st_exec: begin
               cyc_left <= cyc_left - 4'h1;
               if (cyc_left == 4'h1) begin
                  state <= st_done;
               end
            end
            default: state <= st_idle;
         endcase
      end
   end

   // Latch instruction
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         cur_op <= no_operation;
         cur_mode <= mode_immediate;
         cur_opcode <= 8'h00;
         cur_b2 <= 8'h00;
         cur_b3 <= 8'h00;
         cur_bit <= 3'h0;
         cur_pc <= PC_RESET;
         instr_len <= LEN_1;
      end else if (start && state != st_exec) begin
         cur_op <= (op == stop_op && watchdog_selected) ? wait_op : op; // RQ10
         cur_mode <= mode;
         cur_opcode <= opcode;
         cur_b2 <= byte2;
         cur_b3 <= byte3;
         cur_bit <= bit_index;
         cur_pc <= pc_in;
         instr_len <= next_len;
      end
   end

   // Accumulator commit
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         acc <= ACC_RESET;
      end else if (last) begin // RQ21
         if (is_acc_op(cur_op) && cur_op != compare_op) begin // RQ3 RQ11
            acc <= alu_res;
         end else if (is_acc_form(cur_op, cur_mode, cur_opcode)) begin // RQ13
            acc <= alu_res;
         end
      end
   end

   // Zero flag commit
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         zero_flag <= 1'b0;
      end else if (last) begin // RQ21
         if (cur_op == compare_op) begin
            zero_flag <= (acc == operand); // RQ11
         end else if (is_acc_op(cur_op) || is_acc_form(cur_op, cur_mode, cur_opcode)) begin
            zero_flag <= (alu_res == 8'h00); // RQ11 RQ13
         end else if (cur_op == increment_op || cur_op == decrement_op) begin
            zero_flag <= (alu_res == 8'h00); // RQ12
         end else if (cur_op == return_from_interrupt) begin
            zero_flag <= saved_flags[0]; // RQ17
         end
      end
   end

   // Carry flag commit
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         carry_flag <= 1'b0;
      end else if (last) begin // RQ21
         if (is_acc_op(cur_op)) begin
            carry_flag <= alu_carry; // RQ11
         end else if (cur_op == clear_op && is_acc_form(cur_op, cur_mode, cur_opcode)) begin
            carry_flag <= 1'b0; // RQ13
         end else if (is_bit_test(cur_op)) begin
            carry_flag <= tested_bit; // RQ9
         end else if (cur_op == return_from_interrupt) begin
            carry_flag <= saved_flags[1]; // RQ17
         end
      end
   end

   // Program counter
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         pc <= PC_RESET;
      end else if (last) begin // RQ21
         pc <= next_pc;
      end
   end

   // Low-power mode pulses after the final cycle
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         stop_mode <= 1'b0;
         wait_mode <= 1'b0;
      end else begin
         stop_mode <= last && (cur_op == stop_op);
         wait_mode <= last && (cur_op == wait_op); // RQ10
      end
   end

   assign busy = (state == st_exec);
   assign done = (state == st_done);
   assign push_return = last && (cur_op == call_op);
   assign pop_return = last && (cur_op == subroutine_return || cur_op == return_from_interrupt);
endmodule

// ### verilog/core_exec_pkg.sv
/*
 Constants for the 8-bit core execution block: instruction classes, lengths,
 cycle counts, reset values and field positions.
 Assumes one clock domain and an external decoder that classifies opcodes.
*/
package core_exec_pkg;
   localparam int DATA_W = 8;
   localparam int DADDR_W = 8;
   localparam int PADDR_W = 12;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [11:0] PC_RESET = 12'h000;
   localparam logic [11:0] BIT_BR_BASE = 12'h002;
   localparam logic [7:0] PTR_X_ADDR = 8'h80;
   localparam logic [7:0] PTR_Y_ADDR = 8'h81;
   localparam int PTR_SEL_BIT = 4;
   localparam int DIR_BIT = 4;
   localparam logic [3:0] CYC_ALU = 4'h4;
   localparam logic [3:0] CYC_BR_REL = 4'h2;
   localparam logic [3:0] CYC_BR_BIT = 4'h5;
   localparam logic [3:0] CYC_BIT_OP = 4'h4;
   localparam logic [3:0] CYC_CTRL = 4'h2;
   localparam logic [3:0] CYC_JUMP = 4'h4;
   localparam logic [1:0] LEN_1 = 2'h1;
   localparam logic [1:0] LEN_2 = 2'h2;
   localparam logic [1:0] LEN_3 = 2'h3;

   typedef enum logic [4:0] {
      add_op = 5'h00, and_op = 5'h01, compare_op = 5'h02, subtract_op = 5'h03,
      clear_op = 5'h04, decrement_op = 5'h05, increment_op = 5'h06,
      complement_accumulator = 5'h07, rotate_left_through_carry = 5'h08,
      shift_left_accumulator = 5'h09, branch_if_carry = 5'h0A, branch_if_no_carry = 5'h0B,
      branch_if_zero = 5'h0C, branch_if_nonzero = 5'h0D, branch_if_bit_clear = 5'h0E,
      branch_if_bit_set = 5'h0F, bit_set_op = 5'h10, bit_clear_op = 5'h11,
      no_operation = 5'h12, subroutine_return = 5'h13, return_from_interrupt = 5'h14,
      stop_op = 5'h15, wait_op = 5'h16, long_jump = 5'h17, call_op = 5'h18
   } op_e;

   typedef enum logic [1:0] {
      mode_immediate = 2'h0, mode_direct = 2'h1, mode_short_direct = 2'h2, mode_indirect = 2'h3
   } mode_e;

   typedef enum logic [1:0] {
      st_idle = 2'b00, st_exec = 2'b01, st_done = 2'b11
   } state_e;
endpackage
